// [hdl/lfc_core.sv]
// Flag, command and output processing core with Wishbone slave
// How it works
// - Average step counts and sums input value
// - Final step divides, stores quotient, clears total
// - Results go final storage unless redirected
// - Sample taken only when average instruction runs
// - Final processing only while output flag high
// - Ten flags; flags 0, 9 cleared at start
// - User flags kept across table starts
// - False test on flag 0/9 clears it
// - False test leaves user flag unchanged
// - Suppress flag high skips all accumulation
// - Time test: minutes into interval, run command
// - Intervals aligned to midnight, day restarts alignment
// - Code zero true ends current table
// - Subroutine codes call subroutine of that number
// - Port codes set, clear, toggle, pulse ports
// - Then-do true runs block, false skips it
// - ELSE runs on false; END closes branch
// - Operator toggles user flags; tests see them
//
// The Wishbone slave port and the address map were chosen for this implementation.
module lfc_core #(
   parameter int unsigned MINUTE_CYCLES = 32'(lfc_pkg::MINUTE_CYC),
   parameter int unsigned PULSE_CYCLES = 32'(lfc_pkg::PULSE_CYC)
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [5:0] port_o,
   output lfc_pkg::lfc_call_t call_o,
   output logic table_end_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_FIN} lfc_state_t;

   lfc_state_t st_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [9:0] flags_q;
   logic [9:0] flags_d;
   logic [31:0] arg_q;
   logic [31:0] tot_q;
   logic [31:0] cnt_q;
   logic [31:0] res_fin_q;
   logic [31:0] res_in_q;
   logic [10:0] tod_q;
   logic [31:0] min_cnt_q;
   logic [3:0] skip_q;
   logic ended_q;
   logic dest_q;
   logic [5:0] port_q;
   logic [31:0] pcnt_q [lfc_pkg::NPORT];
   logic [31:0] dnum_q;
   logic [31:0] dden_q;
   logic [31:0] drem_q;
   logic [4:0] dcnt_q;
   logic dmode_q;
   logic [10:0] toff_q;
   logic [7:0] tcode_q;
   logic tval_q;
   lfc_pkg::lfc_call_t call_q;
   logic end_q;
   logic [31:0] wmask;
   logic [31:0] rq;
   logic ge;
   logic cmd_v;
   logic cmd_c;
   logic [7:0] cmd_code;
   logic [3:0] fset;
   logic [3:0] fclr;
   logic [31:0] nt;
   logic [31:0] nc;
   lfc_pkg::lfc_instr_t ins;
   lfc_pkg::lfc_targ_t targ;
   lfc_pkg::lfc_status_t stat;

   // Bus handshake
   logic req, busy, is_ins, take, wr, exec, live, div_done, avg_go;
   assign req = wb_cyc_i & wb_stb_i & ~ack_q;
   assign busy = st_q != ST_IDLE;
   assign is_ins = wb_adr_i == lfc_pkg::ADR_INSTR;
   assign take = req & ~(wb_we_i & is_ins & busy);
   assign wr = take & wb_we_i;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign ins = lfc_pkg::lfc_instr_t'(wb_dat_i);
   assign targ = lfc_pkg::lfc_targ_t'(arg_q);
   assign exec = wr & is_ins;
   assign live = exec & (skip_q == 4'h0) & ~ended_q;
   assign div_done = st_q == ST_FIN;
   assign avg_go = live & (ins.op == lfc_pkg::OP_AVG);
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign port_o = port_q;
   assign call_o = call_q;
   assign table_end_o = end_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= take;
      end
   end

   always_comb begin
      stat = '0;
      stat.busy = busy;
      stat.ended = ended_q;
      stat.dest = dest_q;
      stat.skip = skip_q;
      stat.port = port_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0;
      end else if (take && !wb_we_i) begin
         case (wb_adr_i)
            lfc_pkg::ADR_FLAGS: dat_q <= {22'h0, flags_q};
            lfc_pkg::ADR_ARG: dat_q <= arg_q;
            lfc_pkg::ADR_STATUS: dat_q <= 32'(stat);
            lfc_pkg::ADR_TOD: dat_q <= {21'h0, tod_q};
            lfc_pkg::ADR_RES_FIN: dat_q <= res_fin_q;
            lfc_pkg::ADR_RES_IN: dat_q <= res_in_q;
            lfc_pkg::ADR_TOTAL: dat_q <= tot_q;
            lfc_pkg::ADR_COUNT: dat_q <= cnt_q;
            default: dat_q <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         arg_q <= 32'h0;
      end else if (wr && wb_adr_i == lfc_pkg::ADR_ARG) begin
         arg_q <= (arg_q & ~wmask) | (wb_dat_i & wmask);
      end
   end

   // Command source: direct command or finished time test
   always_comb begin
      cmd_v = 1'b0;
      cmd_c = 1'b0;
      cmd_code = 8'h0;
      if (live && ins.op == lfc_pkg::OP_CMD) begin
         cmd_v = 1'b1;
         cmd_c = ins.cond;
         cmd_code = ins.code;
      end else if (div_done && dmode_q) begin
         cmd_v = 1'b1;
         cmd_c = tval_q && (drem_q[10:0] == toff_q);
         cmd_code = tcode_q;
      end
   end

   // Flags
   always_comb begin
      flags_d = flags_q;
      fset = 4'(cmd_code - lfc_pkg::CC_SET_LO);
      fclr = 4'(cmd_code - lfc_pkg::CC_CLR_LO);
      if (wr && wb_adr_i == lfc_pkg::ADR_FLAGS) begin
         flags_d = flags_q ^ (wb_dat_i[lfc_pkg::NFLAG-1:0] & lfc_pkg::USER_MASK);
      end
      if (exec && ins.op == lfc_pkg::OP_START) begin
         flags_d[lfc_pkg::FLG_OUT] = 1'b0;
         flags_d[lfc_pkg::FLG_SUP] = 1'b0;
      end
      if (cmd_v && cmd_code >= lfc_pkg::CC_SET_LO && cmd_code <= lfc_pkg::CC_SET_HI) begin
         if (cmd_c) begin
            flags_d[fset] = 1'b1;
         end else if (fset == lfc_pkg::FLG_OUT || fset == lfc_pkg::FLG_SUP) begin
            flags_d[fset] = 1'b0;
         end
      end
      if (cmd_v && cmd_c && cmd_code >= lfc_pkg::CC_CLR_LO && cmd_code <= lfc_pkg::CC_CLR_HI) begin
         flags_d[fclr] = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_q <= 10'h0;
      end else begin
         flags_q <= flags_d;
      end
   end

   // Branch skipping depth
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         skip_q <= 4'h0;
      end else if (exec && ins.op == lfc_pkg::OP_START) begin
         skip_q <= 4'h0;
      end else if (exec && ins.op == lfc_pkg::OP_ELSE) begin
         if (skip_q == 4'h1) begin
            skip_q <= 4'h0;
         end else if (skip_q == 4'h0) begin
            skip_q <= 4'h1;
         end
      end else if (exec && ins.op == lfc_pkg::OP_END && skip_q != 4'h0) begin
         skip_q <= skip_q - 4'h1;
      end else if (exec && skip_q != 4'h0 && ins.code == lfc_pkg::CC_THEN &&
                   (ins.op == lfc_pkg::OP_CMD || ins.op == lfc_pkg::OP_TIME)) begin
         skip_q <= skip_q + 4'h1;
      end else if (cmd_v && !cmd_c && cmd_code == lfc_pkg::CC_THEN) begin
         skip_q <= 4'h1;
      end
   end

   // Table end and subroutine calls
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ended_q <= 1'b0;
         end_q <= 1'b0;
         call_q <= '0;
      end else begin
         end_q <= cmd_v && cmd_c && cmd_code == lfc_pkg::CC_END;
         if (exec && ins.op == lfc_pkg::OP_START) begin
            ended_q <= 1'b0;
         end else if (cmd_v && cmd_c && cmd_code == lfc_pkg::CC_END) begin
            ended_q <= 1'b1;
         end
         call_q.valid <= cmd_v && cmd_c &&
            ((cmd_code >= lfc_pkg::CC_SUB_LO && cmd_code <= lfc_pkg::CC_SUB_HI) ||
             (cmd_code >= lfc_pkg::CC_SUB2_LO && cmd_code <= lfc_pkg::CC_SUB2_HI));
         call_q.num <= cmd_code;
      end
   end

   // Output ports
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_q <= 6'h0;
         for (int i = 0; i < lfc_pkg::NPORT; i++) begin
            pcnt_q[i] <= 32'h0;
         end
      end else begin
         for (int i = 0; i < lfc_pkg::NPORT; i++) begin
            if (pcnt_q[i] != 32'h0) begin
               pcnt_q[i] <= pcnt_q[i] - 32'h1;
               if (pcnt_q[i] == 32'h1) begin
                  port_q[i] <= 1'b0;
               end
            end
            if (cmd_v && cmd_c) begin
               if (cmd_code == lfc_pkg::CC_PHI + 8'(i + 1)) begin
                  port_q[i] <= 1'b1;
                  pcnt_q[i] <= 32'h0;
               end else if (cmd_code == lfc_pkg::CC_PLO + 8'(i + 1)) begin
                  port_q[i] <= 1'b0;
                  pcnt_q[i] <= 32'h0;
               end else if (cmd_code == lfc_pkg::CC_PTG + 8'(i + 1)) begin
                  port_q[i] <= ~port_q[i];
                  pcnt_q[i] <= 32'h0;
               end else if (cmd_code == lfc_pkg::CC_PPU + 8'(i + 1)) begin
                  port_q[i] <= 1'b1;
                  pcnt_q[i] <= PULSE_CYCLES;
               end
            end
         end
      end
   end

   // Time of day in minutes, wraps at midnight
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tod_q <= 11'h0;
         min_cnt_q <= 32'h0;
      end else if (wr && wb_adr_i == lfc_pkg::ADR_TOD) begin
         tod_q <= (wb_dat_i[10:0] < lfc_pkg::DAY_MIN) ? wb_dat_i[10:0] : 11'h0;
         min_cnt_q <= 32'h0;
      end else if (min_cnt_q == MINUTE_CYCLES - 32'h1) begin
         min_cnt_q <= 32'h0;
         tod_q <= (tod_q == lfc_pkg::DAY_MIN - 11'h1) ? 11'h0 : tod_q + 11'h1;
      end else begin
         min_cnt_q <= min_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dest_q <= 1'b0;
      end else if (live && ins.op == lfc_pkg::OP_REDIR) begin
         dest_q <= ins.dest;
      end
   end

   // Accumulation
   always_comb begin
      nt = flags_q[lfc_pkg::FLG_SUP] ? tot_q : tot_q + arg_q;
      nc = flags_q[lfc_pkg::FLG_SUP] ? cnt_q : cnt_q + 32'h1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tot_q <= 32'h0;
         cnt_q <= 32'h0;
      end else if (avg_go) begin
         if (flags_q[lfc_pkg::FLG_OUT]) begin
            tot_q <= 32'h0;
            cnt_q <= 32'h0;
         end else begin
            tot_q <= nt;
            cnt_q <= nc;
         end
      end
   end

   // Shared divider for averages and interval remainders
   assign rq = {drem_q[30:0], dnum_q[31]};
   assign ge = rq >= dden_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= ST_IDLE;
         dnum_q <= 32'h0;
         dden_q <= 32'h0;
         drem_q <= 32'h0;
         dcnt_q <= 5'h0;
         dmode_q <= 1'b0;
         toff_q <= 11'h0;
         tcode_q <= 8'h0;
         tval_q <= 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               dcnt_q <= 5'h0;
               drem_q <= 32'h0;
               if (avg_go && flags_q[lfc_pkg::FLG_OUT]) begin
                  st_q <= ST_DIV;
                  dmode_q <= 1'b0;
                  dnum_q <= nt;
                  dden_q <= nc;
               end else if (live && ins.op == lfc_pkg::OP_TIME) begin
                  st_q <= ST_DIV;
                  dmode_q <= 1'b1;
                  dnum_q <= 32'(tod_q);
                  dden_q <= 32'(targ.interval);
                  toff_q <= targ.offset;
                  tcode_q <= ins.code;
                  tval_q <= targ.interval != 11'h0;
               end
            end
            ST_DIV: begin
               dnum_q <= {dnum_q[30:0], ge};
               drem_q <= ge ? rq - dden_q : rq;
               dcnt_q <= dcnt_q + 5'h1;
               if (dcnt_q == lfc_pkg::DIV_LAST) begin
                  st_q <= ST_FIN;
               end
            end
            ST_FIN: st_q <= ST_IDLE;
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res_fin_q <= 32'h0;
         res_in_q <= 32'h0;
      end else if (div_done && !dmode_q) begin
         if (dest_q) begin
            res_in_q <= (dden_q == 32'h0) ? 32'h0 : dnum_q;
         end else begin
            res_fin_q <= (dden_q == 32'h0) ? 32'h0 : dnum_q;
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_start_clears: assert property (
      exec && ins.op == lfc_pkg::OP_START |=> !flags_q[0] && !flags_q[9])
      else $error("start did not clear flags 0 and 9");
   a_user_kept: assert property (
      exec && ins.op == lfc_pkg::OP_START |=> flags_q[8:1] == $past(flags_q[8:1]))
      else $error("user flags changed at start");
   a_false_clears: assert property (
      cmd_v && !cmd_c && cmd_code == lfc_pkg::CC_SET_LO |=> !flags_q[0])
      else $error("false test left output flag high");
   a_false_keeps: assert property (
      cmd_v && !cmd_c && cmd_code > lfc_pkg::CC_SET_LO && cmd_code < lfc_pkg::CC_SET_HI &&
      !(wr && wb_adr_i == lfc_pkg::ADR_FLAGS) |=> $stable(flags_q[8:1]))
      else $error("false test changed user flag");
   a_accum_step: assert property (
      avg_go && flags_q == 10'h0 |=> cnt_q == $past(cnt_q) + 32'h1)
      else $error("sample count not incremented");
   a_suppress_hold: assert property (
      avg_go && flags_q[9] && !flags_q[0] |=> $stable(tot_q) && $stable(cnt_q))
      else $error("accumulated while suppressed");
   a_final_gate: assert property (
      avg_go && !flags_q[0] |=> st_q == ST_IDLE)
      else $error("final processing without output flag");
   a_final_done: assert property (
      avg_go && flags_q[0] |=> cnt_q == 32'h0 ##32 div_done ##1 st_q == ST_IDLE)
      else $error("final processing timing wrong");
   a_end_jump: assert property (
      cmd_v && cmd_c && cmd_code == lfc_pkg::CC_END |=> end_q && ended_q ##1 !end_q)
      else $error("table end not signalled");
   a_then_skip: assert property (
      cmd_v && !cmd_c && cmd_code == lfc_pkg::CC_THEN |=> skip_q == 4'h1)
      else $error("false then-do not skipped");
endmodule // lfc_core

// [hdl/lfc_pkg.sv]
// Shared constants and types of the logger flag command block
package lfc_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int MINUTE_S = 60;
   localparam longint MINUTE_CYC = longint'(MINUTE_S) * longint'(CLK_HZ);
   localparam int PULSE_MS = 100;
   localparam longint PULSE_CYC = longint'(PULSE_MS) * longint'(CLK_HZ / 1000);
   localparam logic [10:0] DAY_MIN = 11'h5a0;
   localparam int NFLAG = 10;
   localparam int NPORT = 6;
   localparam logic [3:0] FLG_OUT = 4'h0;
   localparam logic [3:0] FLG_SUP = 4'h9;
   localparam logic [9:0] USER_MASK = 10'h1fe;
   localparam logic [4:0] DIV_LAST = 5'h1f;
   // Register byte addresses
   localparam logic [7:0] ADR_FLAGS = 8'h00;
   localparam logic [7:0] ADR_INSTR = 8'h04;
   localparam logic [7:0] ADR_ARG = 8'h08;
   localparam logic [7:0] ADR_STATUS = 8'h0c;
   localparam logic [7:0] ADR_TOD = 8'h10;
   localparam logic [7:0] ADR_RES_FIN = 8'h14;
   localparam logic [7:0] ADR_RES_IN = 8'h18;
   localparam logic [7:0] ADR_TOTAL = 8'h1c;
   localparam logic [7:0] ADR_COUNT = 8'h20;
   // Command codes
   localparam logic [7:0] CC_END = 8'h00;
   localparam logic [7:0] CC_SUB_LO = 8'h01;
   localparam logic [7:0] CC_SUB_HI = 8'h09;
   localparam logic [7:0] CC_SET_LO = 8'h0a;
   localparam logic [7:0] CC_SET_HI = 8'h13;
   localparam logic [7:0] CC_CLR_LO = 8'h14;
   localparam logic [7:0] CC_CLR_HI = 8'h1d;
   localparam logic [7:0] CC_THEN = 8'h1e;
   localparam logic [7:0] CC_PHI = 8'h28;
   localparam logic [7:0] CC_PLO = 8'h32;
   localparam logic [7:0] CC_PTG = 8'h3c;
   localparam logic [7:0] CC_PPU = 8'h46;
   localparam logic [7:0] CC_SUB2_LO = 8'h4d;
   localparam logic [7:0] CC_SUB2_HI = 8'h63;
   typedef enum logic [3:0] {
      OP_NOP, OP_START, OP_AVG, OP_REDIR, OP_CMD, OP_TIME, OP_ELSE, OP_END
   } lfc_op_t;
   typedef struct packed {
      lfc_op_t op;
      logic cond;
      logic [17:0] rsv;
      logic dest;
      logic [7:0] code;
   } lfc_instr_t;
   typedef struct packed {
      logic [4:0] rsv_hi;
      logic [10:0] interval;
      logic [4:0] rsv_lo;
      logic [10:0] offset;
   } lfc_targ_t;
   typedef struct packed {
      logic [17:0] rsv;
      logic busy;
      logic ended;
      logic dest;
      logic [3:0] skip;
      logic rsv_mid;
      logic [5:0] port;
   } lfc_status_t;
   typedef struct packed {
      logic valid;
      logic [7:0] num;
   } lfc_call_t;
endpackage

// [testbench/lfc_prog_model.sv]
// Stored program table model feeding the command block
module lfc_prog_model (
   input wire logic [3:0] idx_i,
   output lfc_pkg::lfc_instr_t ins_o,
   output logic [31:0] arg_o
);
   timeunit 1ns;
   timeprecision 1ns;

   function automatic lfc_pkg::lfc_instr_t mk(lfc_pkg::lfc_op_t op, logic c, logic [7:0] k);
      mk = '{op: op, cond: c, rsv: 18'h0, dest: 1'b0, code: k};
   endfunction

   assign arg_o = (idx_i == 4'h1) ? 32'h4 : (idx_i == 4'h2) ? 32'h8 : (idx_i == 4'h4) ? 32'hc : 32'h0;

   always_comb begin
      case (idx_i)
         4'h0: ins_o = mk(lfc_pkg::OP_START, 1'b0, 8'h00);
         4'h1: ins_o = mk(lfc_pkg::OP_AVG, 1'b0, 8'h00);
         4'h2: ins_o = mk(lfc_pkg::OP_AVG, 1'b0, 8'h00);
         4'h3: ins_o = mk(lfc_pkg::OP_CMD, 1'b1, 8'h0a); // Output flag ahead of group
         4'h4: ins_o = mk(lfc_pkg::OP_AVG, 1'b0, 8'h00);
         4'h5: ins_o = mk(lfc_pkg::OP_CMD, 1'b0, 8'h1e);
         4'h6: ins_o = mk(lfc_pkg::OP_CMD, 1'b1, 8'h29);
         4'h7: ins_o = mk(lfc_pkg::OP_ELSE, 1'b0, 8'h00);
         4'h8: ins_o = mk(lfc_pkg::OP_CMD, 1'b1, 8'h2a);
         4'ha: ins_o = mk(lfc_pkg::OP_CMD, 1'b1, 8'h1e);
         4'hb: ins_o = mk(lfc_pkg::OP_CMD, 1'b1, 8'h2b);
         4'hc: ins_o = mk(lfc_pkg::OP_ELSE, 1'b0, 8'h00);
         4'hd: ins_o = mk(lfc_pkg::OP_CMD, 1'b1, 8'h2c);
         default: ins_o = mk(lfc_pkg::OP_END, 1'b0, 8'h00);
      endcase
   end
endmodule // lfc_prog_model

// [testbench/logger_flag_command_control_tb_top.sv]
// Testbench of the logger flag command block
module logger_flag_command_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   logic [5:0] port;
   lfc_pkg::lfc_call_t call;
   logic tend;
   logic [3:0] pidx = 4'h0;
   lfc_pkg::lfc_instr_t pins;
   logic [31:0] parg;
   int error_cnt = 0;
   int samples_checked = 0;
   int ncall = 0;
   int nend = 0;
   int plen = 0;
   logic [7:0] lastnum = 8'h00;
   logic [31:0] q;
   localparam logic [31:0] START = {lfc_pkg::OP_START, 28'h0};
   localparam logic [31:0] AVG = {lfc_pkg::OP_AVG, 28'h0};

   initial begin
      forever #25 clk_i = ~clk_i;
   end

   lfc_core #(.MINUTE_CYCLES(1000), .PULSE_CYCLES(5)) lfc_core_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .port_o(port), .call_o(call), .table_end_o(tend));

   lfc_prog_model lfc_prog_model_inst (.idx_i(pidx), .ins_o(pins), .arg_o(parg));

   always @(posedge clk_i) begin
      if (call.valid === 1'b1) begin
         ncall++;
         lastnum = call.num;
      end
      if (tend === 1'b1) nend++;
      if (port[2] === 1'b1) plen++;
   end

   task automatic results();
      if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      wdat <= d;
      @(negedge clk_i);
      while (ack !== 1'b1 && n < 100) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 100) error_cnt++;
      @(posedge clk_i);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic exe(input logic [31:0] ins, input logic [31:0] arg);
      bus(1'b1, lfc_pkg::ADR_ARG, arg);
      bus(1'b1, lfc_pkg::ADR_INSTR, ins);
      q = 32'h2000;
      for (int k = 0; k < 60 && q[13] !== 1'b0; k++) bus(1'b0, lfc_pkg::ADR_STATUS, 32'h0);
      if (q[13] !== 1'b0) error_cnt++;
   endtask

   function automatic logic [31:0] cmd(input logic c, input logic [7:0] k);
      cmd = {lfc_pkg::OP_CMD, c, 18'h0, 1'b0, k};
   endfunction

   task automatic tm(input logic [7:0] k, input logic [10:0] off);
      exe({lfc_pkg::OP_TIME, 1'b1, 19'h0, k}, {5'h0, 11'h7, 5'h0, off});
   endtask

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic run(input int a, input int b);
      for (int k = a; k <= b; k++) begin
         pidx <= 4'(k);
         @(posedge clk_i);
         exe(pins, parg);
      end
   endtask

   initial begin
      repeat (60000) @(posedge clk_i);
      error_cnt++;
      results();
   end

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(lfc_pkg::ADR_FLAGS);
      chk("flags", q, 32'h0);
      rd(lfc_pkg::ADR_STATUS);
      chk("status", q, 32'h0);
      run(0, 2);
      rd(lfc_pkg::ADR_TOTAL);
      chk("total", q, 32'hc);
      rd(lfc_pkg::ADR_COUNT);
      chk("count", q, 32'h2);
      rd(lfc_pkg::ADR_RES_FIN);
      chk("final", q, 32'h0);
      bus(1'b1, lfc_pkg::ADR_ARG, 32'h64);
      rd(lfc_pkg::ADR_TOTAL);
      chk("total", q, 32'hc);
      run(3, 4);
      rd(lfc_pkg::ADR_RES_FIN);
      chk("final", q, 32'h8);
      rd(lfc_pkg::ADR_TOTAL);
      chk("total", q, 32'h0);
      rd(lfc_pkg::ADR_COUNT);
      chk("count", q, 32'h0);
      exe(cmd(1'b0, 8'h0a), 32'h0);
      rd(lfc_pkg::ADR_FLAGS);
      chk("flags", q, 32'h0);
      exe(cmd(1'b1, 8'h0b), 32'h0);
      exe(cmd(1'b0, 8'h0b), 32'h0);
      rd(lfc_pkg::ADR_FLAGS);
      chk("flags", q, 32'h2);
      for (int k = 0; k < 10; k++) exe(cmd(1'b1, 8'h0a + 8'(k)), 32'h0);
      rd(lfc_pkg::ADR_FLAGS);
      chk("flags", q, 32'h3ff);
      exe(START, 32'h0);
      rd(lfc_pkg::ADR_FLAGS);
      chk("flags", q, 32'h1fe);
      for (int k = 0; k < 10; k++) exe(cmd(1'b1, 8'h14 + 8'(k)), 32'h0);
      rd(lfc_pkg::ADR_FLAGS);
      chk("flags", q, 32'h0);
      bus(1'b1, lfc_pkg::ADR_FLAGS, 32'h207);
      rd(lfc_pkg::ADR_FLAGS);
      chk("flags", q, 32'h6);
      exe(cmd(1'b1, 8'h13), 32'h0);
      exe(AVG, 32'h5);
      rd(lfc_pkg::ADR_COUNT);
      chk("count", q, 32'h0);
      exe(cmd(1'b1, 8'h1d), 32'h0);
      exe({lfc_pkg::OP_REDIR, 19'h0, 1'b1, 8'h0}, 32'h0);
      exe(cmd(1'b1, 8'h0a), 32'h0);
      exe(AVG, 32'h9);
      rd(lfc_pkg::ADR_RES_IN);
      chk("input", q, 32'h9);
      rd(lfc_pkg::ADR_RES_FIN);
      chk("final", q, 32'h8);
      rd(lfc_pkg::ADR_STATUS);
      chk("status", q, 32'h800);
      exe({lfc_pkg::OP_REDIR, 28'h0}, 32'h0);
      for (int k = 0; k < 6; k++) exe(cmd(1'b1, 8'h29 + 8'(k)), 32'h0);
      chk("port", 32'(port), 32'h3f);
      for (int k = 0; k < 6; k++) exe(cmd(1'b1, 8'h33 + 8'(k)), 32'h0);
      chk("port", 32'(port), 32'h0);
      for (int k = 0; k < 6; k++) exe(cmd(1'b1, 8'h3d + 8'(k)), 32'h0);
      chk("port", 32'(port), 32'h3f);
      for (int k = 0; k < 6; k++) exe(cmd(1'b1, 8'h33 + 8'(k)), 32'h0);
      plen = 0;
      exe(cmd(1'b1, 8'h49), 32'h0);
      repeat (10) @(posedge clk_i);
      chk("pulse", 32'(plen), 32'h5);
      run(5, 14);
      chk("port", 32'(port), 32'h6);
      exe(cmd(1'b1, 8'h05), 32'h0);
      exe(cmd(1'b1, 8'h4d), 32'h0);
      exe(cmd(1'b0, 8'h09), 32'h0);
      chk("calls", 32'(ncall), 32'h2);
      chk("callnum", 32'(lastnum), 32'h4d);
      exe(cmd(1'b0, 8'h00), 32'h0);
      chk("ends", 32'(nend), 32'h0);
      exe(cmd(1'b1, 8'h00), 32'h0);
      exe(cmd(1'b1, 8'h2c), 32'h0);
      chk("ends", 32'(nend), 32'h1);
      chk("port", 32'(port), 32'h6);
      rd(lfc_pkg::ADR_STATUS);
      chk("ended", 32'(q[12]), 32'h1);
      exe(START, 32'h0);
      bus(1'b1, lfc_pkg::ADR_TOD, 32'h59f);
      q = 32'h59f;
      for (int k = 0; k < 2000 && q === 32'h59f; k++) rd(lfc_pkg::ADR_TOD);
      chk("tod", q, 32'h0);
      exe(cmd(1'b1, 8'h15), 32'h0);
      exe(cmd(1'b1, 8'h16), 32'h0);
      tm(8'h0b, 11'h0);
      rd(lfc_pkg::ADR_FLAGS);
      chk("flags", q, 32'h2);
      bus(1'b1, lfc_pkg::ADR_TOD, 32'h59f);
      tm(8'h0c, 11'h4);
      rd(lfc_pkg::ADR_FLAGS);
      chk("flags", q, 32'h6);
      exe(cmd(1'b1, 8'h0a), 32'h0);
      tm(8'h0a, 11'h0);
      rd(lfc_pkg::ADR_FLAGS);
      chk("flags", q, 32'h6);
      bus(1'b1, lfc_pkg::ADR_TOD, 32'h5a0);
      rd(lfc_pkg::ADR_TOD);
      chk("tod", q, 32'h0);
      rd(8'h40);
      chk("unmapped", q, 32'h0);
      results();
   end
endmodule // logger_flag_command_control_tb_top
